/* File: pkg/osc_ctrl_defs.vh */
`ifndef OSC_CTRL_DEFS_VH
`define OSC_CTRL_DEFS_VH
// ==========================================
// Register byte addresses
`define ADDR_OSC_CTRL 12'h000
`define ADDR_CLK_DIV 12'h004
// ==========================================
// Oscillator control fields
`define OC_CUR_HI 14
`define OC_CUR_LO 12
`define OC_REQ_HI 10
`define OC_REQ_LO 8
`define OC_SEL_LOCK 7
`define OC_IO_LOCK 6
`define OC_PLL_LOCK 5
`define OC_CLK_FAIL 3
`define OC_PRI_KEEP 2
`define OC_SEC_EN 1
`define OC_SWITCH_GO 0
// ==========================================
// Clock divider fields
`define CD_ROI 15
`define CD_DOZE_HI 14
`define CD_DOZE_LO 12
`define CD_DOZE_EN 11
`define CD_RC_HI 10
`define CD_RC_LO 8
`define CD_SYS_HI 7
`define CD_SYS_LO 6
`define CD_RESET 16'h0100
// ==========================================
// Source codes
`define SRC_INT_RC 3'h0
`define SRC_INT_RC_PLL 3'h1
`define SRC_PRIMARY 3'h2
`define SRC_PRIMARY_PLL 3'h3
`define SRC_SECONDARY 3'h4
`define SRC_LOW_POWER_RC 3'h5
`define SRC_RESERVED 3'h6
`define SRC_INT_RC_DIV 3'h7
`define PRI_NONE 2'h3
// ==========================================
// Unlock keys
`define KEY_HI_1 8'h78
`define KEY_HI_2 8'h9a
`define KEY_LO_1 8'h46
`define KEY_LO_2 8'h57
// ==========================================
// Timing
`define SWITCH_WAIT_CYCLES 4'ha
`endif

/* File: hw/unlock_seq.v */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Two-key unlock for one byte lane
module unlock_seq #(
	parameter [7:0] KEY1 = 8'h00,
	parameter [7:0] KEY2 = 8'h00
) (
	input wire i_clk,
	input wire i_reset,
	input wire i_wr,
	input wire i_any_wr,
	input wire [7:0] i_data,
	output wire o_open
);
	reg [1:0] stage_r;
	reg [1:0] stage_nxt;
	assign o_open = (stage_r == 2'h2);
	always @* begin
		stage_nxt = stage_r;
		// Any other write breaks the sequence
		if (i_any_wr) begin
			if (i_wr && i_data == KEY1 && stage_r != 2'h2)
				stage_nxt = 2'h1;
			else if (i_wr && i_data == KEY2 && stage_r == 2'h1)
				stage_nxt = 2'h2;
			else
				stage_nxt = 2'h0;
		end
	end
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset)
			stage_r <= 2'h0;
		else
			stage_r <= stage_nxt;
	end
endmodule // unlock_seq
`default_nettype wire

/* File: hw/doze_divider.v */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Peripheral clock enable at 1:2^n
module doze_divider #(
	parameter W = 7
) (
	input wire i_clk,
	input wire i_reset,
	input wire [2:0] i_ratio,
	output reg o_tick
);
	reg [W-1:0] cnt_r;
	wire [W-1:0] mask;
	assign mask = ~({W{1'b1}} << i_ratio);
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt_r <= {W{1'b0}};
			o_tick <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			o_tick <= ((cnt_r & mask) == {W{1'b0}});
		end
	end
endmodule // doze_divider
`default_nettype wire

/* File: hw/osc_select_clock_divider_control.v */
// Function
// - Switching only when switch cfg high bit zero
// - Fail-safe monitor enabled only when cfg 00
// - Power-on source from initial source cfg
// - Primary submode from cfg; others use 11
// - Erased config starts internal RC divided
// - Current source readable in bits 14:12
// - Requested source bits 10:8, reset from cfg
// - Switch go bit reads zero when done
// - Lock bit blocks switches under monitor
// - Monitor off means never locked
// - PLL lock bit reflects lock status
// - PLL lock cleared on switch, non-PLL mode
// - Clock fail set by monitor, clear only
// - IO lock needs unlock; one-way option
// - Primary keep bit controls Sleep running
// - Secondary enable bit drives 32 kHz oscillator
// - Doze field selects 1:2^n ratio
// - Doze enable applies ratio else 1:1
// - Interrupt clears doze enable when set
// - RC postscaler divides 2^n, 256 top
// - System postscaler divides 1,2,4,8
// - Switching disabled holds go bit zero
// - Wait ten new-clock cycles then change
// - High byte write needs 78h, 9Ah
// - Low byte write needs 46h, 57h
`timescale 1ns/10ps
`default_nettype none
`include "osc_ctrl_defs.vh"
module osc_select_clock_divider_control #(
	parameter [1:0] ERASED_MON_CFG = 2'h3
) (
	input wire i_clk,
	input wire i_reset,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	input wire [3:0] i_pstrb,
	output reg [31:0] o_prdata,
	output reg o_pready,
	output reg o_pslverr,
	input wire i_cfg_erased,
	input wire [1:0] i_switch_monitor_cfg,
	input wire [2:0] i_initial_source_cfg,
	input wire [1:0] i_primary_submode_cfg,
	input wire i_io_lock_one_way_cfg,
	input wire i_pll_locked,
	input wire i_clock_fail_detect,
	input wire i_irq,
	input wire i_sleep,
	output reg [2:0] o_clock_source,
	output reg [1:0] o_primary_submode,
	output reg o_primary_run,
	output reg o_secondary_enable,
	output reg o_fail_safe_monitor,
	output reg o_io_lock_a,
	output reg o_periph_tick,
	output reg [8:0] o_rc_divide,
	output reg [3:0] o_sys_divide
);
	// ==========================================
	// Configuration capture after reset release
	reg cfg_loaded_r;
	reg [1:0] mon_cfg_r;
	reg [2:0] init_src_r;
	reg [1:0] pri_cfg_r;
	reg one_way_r;
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			cfg_loaded_r <= 1'b0;
			mon_cfg_r <= 2'h3;
			init_src_r <= `SRC_INT_RC_DIV;
			pri_cfg_r <= `PRI_NONE;
			one_way_r <= 1'b1;
		end else if (!cfg_loaded_r) begin
			cfg_loaded_r <= 1'b1;
			mon_cfg_r <= i_cfg_erased ? ERASED_MON_CFG : i_switch_monitor_cfg;
			init_src_r <= i_cfg_erased ? `SRC_INT_RC_DIV : i_initial_source_cfg;
			pri_cfg_r <= i_cfg_erased ? `PRI_NONE : i_primary_submode_cfg;
			one_way_r <= i_cfg_erased ? 1'b1 : i_io_lock_one_way_cfg;
		end
	end
	wire switch_ok;
	wire monitor_on;
	assign switch_ok = cfg_loaded_r && !mon_cfg_r[1];
	assign monitor_on = cfg_loaded_r && (mon_cfg_r == 2'h0);

	// ==========================================
	// APB decode
	wire acc;
	wire wr;
	wire hit_oc;
	wire hit_cd;
	assign acc = i_psel && i_penable;
	assign hit_oc = (i_paddr == `ADDR_OSC_CTRL);
	assign hit_cd = (i_paddr == `ADDR_CLK_DIV);
	assign wr = acc && i_pwrite && o_pready;
	wire oc_wr_hi;
	wire oc_wr_lo;
	wire any_hi;
	wire any_lo;
	wire open_hi;
	wire open_lo;
	assign any_hi = wr && hit_oc && i_pstrb[1];
	assign any_lo = wr && hit_oc && i_pstrb[0];
	unlock_seq #(.KEY1(`KEY_HI_1), .KEY2(`KEY_HI_2)) u_unlock_hi (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_wr(any_hi),
		.i_any_wr(wr),
		.i_data(i_pwdata[15:8]),
		.o_open(open_hi)
	);
	unlock_seq #(.KEY1(`KEY_LO_1), .KEY2(`KEY_LO_2)) u_unlock_lo (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_wr(any_lo),
		.i_any_wr(wr),
		.i_data(i_pwdata[7:0]),
		.o_open(open_lo)
	);
	assign oc_wr_hi = any_hi && open_hi;
	assign oc_wr_lo = any_lo && open_lo;

	// ==========================================
	// Oscillator control state
	reg [2:0] cur_src_r;
	reg [2:0] req_src_r;
	reg go_r;
	reg sel_lock_r;
	reg io_lock_r;
	reg pll_lock_r;
	reg fail_r;
	reg pri_keep_r;
	reg sec_en_r;
	reg [3:0] wait_r;
	reg src_init_r;
	wire uses_pll;
	wire locked_out;
	assign uses_pll = (cur_src_r == `SRC_INT_RC_PLL) || (cur_src_r == `SRC_PRIMARY_PLL);
	assign locked_out = monitor_on && sel_lock_r;
	wire go_set;
	assign go_set = oc_wr_lo && i_pwdata[`OC_SWITCH_GO] && switch_ok && !locked_out;
	wire valid_start;
	assign valid_start = go_r && wait_r == 4'h0 && req_src_r != cur_src_r && req_src_r != `SRC_RESERVED;

	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			cur_src_r <= `SRC_INT_RC_DIV;
			req_src_r <= `SRC_INT_RC_DIV;
			go_r <= 1'b0;
			sel_lock_r <= 1'b0;
			io_lock_r <= 1'b0;
			pll_lock_r <= 1'b0;
			fail_r <= 1'b0;
			pri_keep_r <= 1'b0;
			sec_en_r <= 1'b0;
			wait_r <= 4'h0;
			src_init_r <= 1'b0;
		end else if (cfg_loaded_r && !src_init_r) begin
			src_init_r <= 1'b1;
			cur_src_r <= init_src_r;
			req_src_r <= init_src_r;
		end else if (src_init_r) begin
			if (oc_wr_hi && !go_r && !locked_out)
				req_src_r <= i_pwdata[`OC_REQ_HI:`OC_REQ_LO];
			if (oc_wr_lo) begin
				pri_keep_r <= i_pwdata[`OC_PRI_KEEP];
				sec_en_r <= i_pwdata[`OC_SEC_EN];
				if (i_pwdata[`OC_SEL_LOCK])
					sel_lock_r <= 1'b1;
				if (!(one_way_r && io_lock_r))
					io_lock_r <= i_pwdata[`OC_IO_LOCK];
				if (!i_pwdata[`OC_CLK_FAIL])
					fail_r <= 1'b0;
			end
			if (monitor_on && i_clock_fail_detect)
				fail_r <= 1'b1;
			if (!switch_ok) begin
				go_r <= 1'b0;
				wait_r <= 4'h0;
			end else if (go_set && !go_r) begin
				go_r <= 1'b1;
			end else if (go_r && wait_r == 4'h0) begin
				if (valid_start) begin
					pll_lock_r <= 1'b0;
					if (!(monitor_on && i_clock_fail_detect))
						fail_r <= 1'b0;
					wait_r <= `SWITCH_WAIT_CYCLES;
				end else begin
					go_r <= 1'b0;
				end
			end else if (wait_r != 4'h0) begin
				if (wait_r == 4'h1) begin
					cur_src_r <= req_src_r;
					go_r <= 1'b0;
				end
				wait_r <= wait_r - 4'h1;
			end
			if (!uses_pll || valid_start || wait_r != 4'h0)
				pll_lock_r <= 1'b0;
			else
				pll_lock_r <= i_pll_locked;
		end
	end

	// ==========================================
	// Clock divider register
	reg [15:0] cd_r;
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			cd_r <= `CD_RESET;
		end else begin
			if (wr && hit_cd && i_pstrb[1])
				cd_r[15:8] <= i_pwdata[15:8];
			if (wr && hit_cd && i_pstrb[0])
				cd_r[7:6] <= i_pwdata[7:6];
			if (cd_r[`CD_ROI] && i_irq)
				cd_r[`CD_DOZE_EN] <= 1'b0;
		end
	end
	wire [2:0] doze_ratio;
	wire tick;
	assign doze_ratio = cd_r[`CD_DOZE_EN] ? cd_r[`CD_DOZE_HI:`CD_DOZE_LO] : 3'h0;
	doze_divider #(.W(7)) u_doze (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_ratio(doze_ratio),
		.o_tick(tick)
	);

	// ==========================================
	// Divide factor decode
	function [8:0] rc_div;
		input [2:0] code;
		begin
			if (code == 3'h7)
				rc_div = 9'h100;
			else
				rc_div = 9'h001 << code;
		end
	endfunction

	// ==========================================
	// Outputs and APB answer
	wire [15:0] oc_read;
	assign oc_read = {1'b0, cur_src_r, 1'b0, req_src_r, sel_lock_r, io_lock_r, pll_lock_r,
		1'b0, fail_r, pri_keep_r, sec_en_r, go_r};
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_prdata <= 32'h0000_0000;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_clock_source <= `SRC_INT_RC_DIV;
			o_primary_submode <= `PRI_NONE;
			o_primary_run <= 1'b0;
			o_secondary_enable <= 1'b0;
			o_fail_safe_monitor <= 1'b0;
			o_io_lock_a <= 1'b0;
			o_periph_tick <= 1'b0;
			o_rc_divide <= 9'h002;
			o_sys_divide <= 4'h1;
		end else begin
			// One wait state: answer in the second access cycle
			o_pready <= i_psel && i_penable && !o_pready;
			o_pslverr <= i_psel && i_penable && !o_pready && !hit_oc && !hit_cd;
			if (i_psel && i_penable && !o_pready && !i_pwrite)
				o_prdata <= hit_oc ? {16'h0000, oc_read} :
					hit_cd ? {16'h0000, cd_r[15:6], 6'h00} : 32'h0000_0000;
			o_clock_source <= cur_src_r;
			o_primary_submode <= (cur_src_r == `SRC_PRIMARY || cur_src_r == `SRC_PRIMARY_PLL) ?
				pri_cfg_r : `PRI_NONE;
			// primary runs in Sleep if kept
			o_primary_run <= (cur_src_r == `SRC_PRIMARY || cur_src_r == `SRC_PRIMARY_PLL ||
				req_src_r == `SRC_PRIMARY || req_src_r == `SRC_PRIMARY_PLL) &&
				(!i_sleep || pri_keep_r);
			o_secondary_enable <= sec_en_r || cur_src_r == `SRC_SECONDARY;
			o_fail_safe_monitor <= monitor_on;
			o_io_lock_a <= io_lock_r;
			o_periph_tick <= tick;
			o_rc_divide <= rc_div(cd_r[`CD_RC_HI:`CD_RC_LO]);
			o_sys_divide <= 4'h1 << cd_r[`CD_SYS_HI:`CD_SYS_LO];
		end
	end
endmodule // osc_select_clock_divider_control
`default_nettype wire

/* File: verification/osc_select_clock_divider_control_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module osc_select_clock_divider_control_monitor #(
	parameter [1:0] ERASED_MON_CFG = 2'h3
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_cfg_erased,
	input wire logic [1:0] i_switch_monitor_cfg,
	input wire logic [1:0] i_primary_submode_cfg,
	input wire logic i_io_lock_one_way_cfg,
	input wire logic [2:0] o_clock_source,
	input wire logic [1:0] o_primary_submode,
	input wire logic o_fail_safe_monitor,
	input wire logic o_io_lock_a,
	input wire logic o_periph_tick,
	input wire logic [8:0] o_rc_divide,
	input wire logic [3:0] o_sys_divide
);
	logic [2:0] up_r;
	logic [7:0] gap_r;
	// Config is only settled a few edges after reset release
	wire run = (up_r == 3'h4);
	wire [1:0] mon = i_cfg_erased ? ERASED_MON_CFG : i_switch_monitor_cfg;
	wire prim = (o_clock_source[2:1] == 2'h1);
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) up_r <= 3'h0;
		else if (!run) up_r <= up_r + 3'h1;
	end
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) gap_r <= 8'h00;
		else gap_r <= o_periph_tick ? 8'h00 : gap_r + 8'h01;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	sequence one_wait_s;
		!o_pready ##1 o_pready;
	endsequence
	// ==========================================
	// Checks
	apb_wait_a: assert property ($rose(i_penable) && i_psel |-> one_wait_s) else $error("ready latency wrong");
	ready_pulse_a: assert property (o_pready |=> !o_pready) else $error("ready held too long");
	err_ready_a: assert property (o_pslverr |-> o_pready) else $error("error without ready");
	monitor_cfg_a: assert property (run |-> o_fail_safe_monitor == (mon == 2'h0)) else $error("monitor enable wrong");
	switch_gate_a: assert property (run && !$stable(o_clock_source) |-> !mon[1]) else $error("switch while disabled");
	prim_submode_a: assert property (run && prim |-> o_primary_submode == i_primary_submode_cfg) else $error("submode wrong");
	other_submode_a: assert property (run && !prim |-> o_primary_submode == 2'h3) else $error("submode not 11");
	io_oneway_a: assert property (run && $past(o_io_lock_a) && (i_io_lock_one_way_cfg || i_cfg_erased)
		|-> o_io_lock_a) else $error("io lock cleared");
	doze_gap_a: assert property (gap_r < 8'h80) else $error("tick gap too long");
	divider_codes_a: assert property ($onehot(o_rc_divide) && !o_rc_divide[7] && $onehot(o_sys_divide))
		else $error("divider factor illegal");
endmodule // osc_select_clock_divider_control_monitor
bind osc_select_clock_divider_control osc_select_clock_divider_control_monitor #(.ERASED_MON_CFG(ERASED_MON_CFG)) osc_select_clock_divider_control_monitor_i (
	.i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .i_cfg_erased(i_cfg_erased), .i_switch_monitor_cfg(i_switch_monitor_cfg),
	.i_primary_submode_cfg(i_primary_submode_cfg), .i_io_lock_one_way_cfg(i_io_lock_one_way_cfg),
	.o_clock_source(o_clock_source), .o_primary_submode(o_primary_submode),
	.o_fail_safe_monitor(o_fail_safe_monitor), .o_io_lock_a(o_io_lock_a), .o_periph_tick(o_periph_tick),
	.o_rc_divide(o_rc_divide), .o_sys_divide(o_sys_divide));
`default_nettype wire

/* File: verification/osc_select_clock_divider_control_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "osc_ctrl_defs.vh"
module osc_select_clock_divider_control_tb_top;
	logic clk, reset, psel, penable, pwrite, pready, pslverr, erased, one_way, pll_ok, fail_det, irq, sleep;
	logic pri_run, sec_en, fsm_on, io_lock, tick;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, v, seed;
	logic [3:0] pstrb, sys_div;
	logic [1:0] mon_cfg, sub_cfg, sub;
	logic [2:0] src_cfg, clk_src;
	logic [8:0] rc_div;
	logic [32:0] e;
	logic [32:0] exp_q[$];
	int error_cnt, tests_run;
	osc_select_clock_divider_control osc_select_clock_divider_control_i (.i_clk(clk), .i_reset(reset), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_cfg_erased(erased), .i_switch_monitor_cfg(mon_cfg),
		.i_initial_source_cfg(src_cfg), .i_primary_submode_cfg(sub_cfg), .i_io_lock_one_way_cfg(one_way),
		.i_pll_locked(pll_ok), .i_clock_fail_detect(fail_det), .i_irq(irq), .i_sleep(sleep),
		.o_clock_source(clk_src), .o_primary_submode(sub), .o_primary_run(pri_run),
		.o_secondary_enable(sec_en), .o_fail_safe_monitor(fsm_on), .o_io_lock_a(io_lock),
		.o_periph_tick(tick), .o_rc_divide(rc_div), .o_sys_divide(sys_div));
	function logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ==========================================
	// APB master, one transfer per call
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [32:0] x);
		exp_q.push_back(x);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
		@(posedge clk) penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		psel <= 1'b0; penable <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000, 4'h0, {1'b0, x});
	endtask
	task unl(input logic hi, input logic [7:0] d);
		if (hi) begin
			apb(1'b1, `ADDR_OSC_CTRL, 32'h0000_7800, 4'h2, 33'h0);
			apb(1'b1, `ADDR_OSC_CTRL, 32'h0000_9a00, 4'h2, 33'h0);
			apb(1'b1, `ADDR_OSC_CTRL, {16'h0000, d, 8'h00}, 4'h2, 33'h0);
		end else begin
			apb(1'b1, `ADDR_OSC_CTRL, 32'h0000_0046, 4'h1, 33'h0);
			apb(1'b1, `ADDR_OSC_CTRL, 32'h0000_0057, 4'h1, 33'h0);
			apb(1'b1, `ADDR_OSC_CTRL, {24'h00_0000, d}, 4'h1, 33'h0);
		end
	endtask
	task ticks(input int n, input int x);
		logic [31:0] c;
		c = 0;
		repeat (n) begin
			@(posedge clk);
			c += tick;
		end
		check("ticks", c, x);
	endtask
	always @(posedge clk) begin
		if (pready === 1'b1) begin
			e = exp_q.pop_front();
			check("pslverr", pslverr, e[32]);
			if (!pwrite) check("prdata", prdata, e[31:0]);
		end
	end
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		report_and_stop;
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb, erased, fail_det, irq, sleep, pll_ok} = '0;
		mon_cfg = 2'h0; src_cfg = 3'h2; sub_cfg = 2'h1; one_way = 1'b1; seed = 32'h0000_0013;
		reset = 1'b1;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		rd(`ADDR_CLK_DIV, 32'h0000_0100);
		rd(`ADDR_OSC_CTRL, 32'h0000_2200);
		check("submode", sub, 2'h1);
		check("monitor", fsm_on, 1'b1);
		apb(1'b0, 12'h008, 32'h0000_0000, 4'h0, 33'h1_0000_0000);
		repeat (4) begin
			seed = xs(seed);
			v = seed & 32'h0000_77c0;
			sleep <= seed[0];
			pll_ok <= seed[1];
			apb(1'b1, `ADDR_CLK_DIV, v, 4'h3, 33'h0);
			rd(`ADDR_CLK_DIV, v);
			check("rc_div", rc_div, (v[10:8] == 3'h7) ? 256 : 1 << v[10:8]);
			check("sys_div", sys_div, 1 << v[7:6]);
			check("pri_run", pri_run, !seed[0]);
		end
		// Keep bit holds the primary up in Sleep
		unl(1'b0, 8'h04);
		sleep <= 1'b1;
		repeat (2) @(posedge clk);
		check("pri_run", pri_run, 1'b1);
		apb(1'b1, `ADDR_CLK_DIV, 32'h0000_f900, 4'h3, 33'h0);
		repeat (8) @(posedge clk);
		ticks(256, 2);
		irq <= 1'b1;
		@(posedge clk) irq <= 1'b0;
		rd(`ADDR_CLK_DIV, 32'h0000_f100);
		ticks(8, 8);
		unl(1'b1, 8'h04);
		unl(1'b0, 8'h01);
		rd(`ADDR_OSC_CTRL, 32'h0000_2401);
		repeat (12) @(posedge clk);
		rd(`ADDR_OSC_CTRL, 32'h0000_4400);
		check("source", clk_src, 3'h4);
		check("submode", sub, 2'h3);
		check("sec_en", sec_en, 1'b1);
		apb(1'b1, `ADDR_OSC_CTRL, 32'h0000_0000, 4'h2, 33'h0);
		rd(`ADDR_OSC_CTRL, 32'h0000_4400);
		unl(1'b1, 8'h06);
		unl(1'b0, 8'h01);
		repeat (4) @(posedge clk);
		rd(`ADDR_OSC_CTRL, 32'h0000_4600);
		fail_det <= 1'b1;
		@(posedge clk) fail_det <= 1'b0;
		rd(`ADDR_OSC_CTRL, 32'h0000_4608);
		unl(1'b0, 8'h40);
		rd(`ADDR_OSC_CTRL, 32'h0000_4640);
		unl(1'b0, 8'h00);
		rd(`ADDR_OSC_CTRL, 32'h0000_4640);
		unl(1'b0, 8'h80);
		unl(1'b1, 8'h00);
		unl(1'b0, 8'h81);
		repeat (14) @(posedge clk);
		rd(`ADDR_OSC_CTRL, 32'h0000_46c0);
		// ==========================================
		// Second power-up: PLL primary, monitor off, two-way io lock
		reset <= 1'b1;
		mon_cfg <= 2'h1;
		src_cfg <= 3'h3;
		sub_cfg <= 2'h2;
		one_way <= 1'b0;
		pll_ok <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		rd(`ADDR_OSC_CTRL, 32'h0000_3320);
		check("submode", sub, 2'h2);
		check("monitor", fsm_on, 1'b0);
		pll_ok <= 1'b0;
		rd(`ADDR_OSC_CTRL, 32'h0000_3300);
		pll_ok <= 1'b1;
		unl(1'b0, 8'hc0);
		unl(1'b1, 8'h00);
		unl(1'b0, 8'h81);
		repeat (14) @(posedge clk);
		rd(`ADDR_OSC_CTRL, 32'h0000_0080);
		check("source", clk_src, 3'h0);
		check("submode", sub, 2'h3);
		// ==========================================
		// Third power-up: erased config, switching off
		reset <= 1'b1;
		erased <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		rd(`ADDR_OSC_CTRL, 32'h0000_7700);
		unl(1'b1, 8'h00);
		unl(1'b0, 8'h01);
		repeat (14) @(posedge clk);
		rd(`ADDR_OSC_CTRL, 32'h0000_7000);
		check("source", clk_src, 3'h7);
		check("monitor", fsm_on, 1'b0);
		report_and_stop;
	end
endmodule // osc_select_clock_divider_control_tb_top
`default_nettype wire
